// [core/fbcd_adapter.sv]
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Commands arrive at class 04, instance 68, attribute 03
// - Status reply is twelve bytes at most
// - Scanner exchanges no faster than once per millisecond
// - Multi-byte data travels least significant byte first
// - Bit 6 set starts, clear stops
// - Bit 7 rising edge resets a trip
// - Bits 6 and 7 together reset and start
// - Bit 13 picks secondary motor set
// - Scanner writes zero to all unused bits
// - Command word held until overwritten or reinitialised
// - Scanner clears commands during override or reset input
// - Error LED flashes on connection timeout
// - Error LED steady on duplicate address
// - Status LED flashes with address, steady when connected
// - Link LED lit while port connected
// - Activity LED flashes on port traffic
// - Serves cyclic exchange and acyclic status reads
// - Discovery network settings are volatile only
// - Status read at class 04, instance 9A, attribute 03
module fbcd_adapter
    import fbcd_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_HALF_CYC,
    parameter int ACT_CYC   = ACT_HOLD_CYC,
    parameter int TMO_CYC   = CONN_TMO_CYC
)
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    fbcd_link_if.adapter link,
    input  wire logic  reinit,
    input  wire logic  ip_obtained,
    input  wire logic  dup_ip,
    input  wire logic  [1:0] link_up,
    input  wire logic  [1:0] port_act,
    input  wire logic  [15:0] starter_state,
    input  wire logic  [31:0] motor_current,
    input  wire logic  [15:0] trip_code,
    input  wire logic  cfg_we,
    input  wire logic  [31:0] cfg_ip_in,
    output logic       start_cmd,
    output logic       trip_reset,
    output logic       motor_set_sec,
    output logic       [15:0] cmd_word,
    output logic       status_read,
    output logic       bad_frame,
    output logic       [31:0] cfg_ip,
    output logic       led_err,
    output logic       led_stat,
    output logic       [1:0] led_link,
    output logic       [1:0] led_act
);
    typedef enum logic [1:0] {ST_RX, ST_EVAL, ST_TX} fbcd_ad_state_t;

    fbcd_ad_state_t state_r;
    logic [5:0]     sync1_r, sync2_r;
    logic [3:0]     cnt_r, tx_idx_r;
    logic [7:0]     cls_r, inst_r, attr_r, tx_data_r;
    logic [31:0]    pay_r, ip_r, wd_r;
    logic [15:0]    cmd_r;
    logic [95:0]    snap_r;
    logic           tx_valid_r, tx_last_r, trip_r, rd_r, bad_r;
    logic           comm_r, tmo_r, led_err_r, led_stat_r, blink;
    logic [1:0]     led_link_r, led_act_r, act_hold;

    // Network status pins are asynchronous to pclk
    wire        s_ip    = sync2_r[0];
    wire        s_dup   = sync2_r[1];
    wire [1:0]  s_link  = sync2_r[3:2];
    wire [1:0]  s_act   = sync2_r[5:4];

    wire        rx_byte  = (state_r == ST_RX) && link.s2d_valid;
    wire        hdr_ok   = (cls_r == ASM_CLASS) && (attr_r == ASM_ATTR);
    wire        is_write = hdr_ok && (inst_r == OUT_INST)
                           && (cnt_r > 4'(HDR_BYTES))
                           && (cnt_r <= 4'(HDR_BYTES + OUT_BYTES));
    wire        is_read  = hdr_ok && (inst_r == IN_INST)
                           && (cnt_r == 4'(HDR_BYTES));
    wire        good     = (state_r == ST_EVAL) && (is_write || is_read);
    wire        tx_end   = (tx_idx_r == 4'(IN_BYTES - 1));
    wire [3:0]  pay_idx  = cnt_r - 4'(HDR_BYTES);
    wire [95:0] snap_nxt = {16'h0000, trip_code, motor_current,
                            16'h0000, starter_state};

    // Frame intake: three path bytes, then payload low byte first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_RX;
            cnt_r   <= '0;
            cls_r   <= '0;
            inst_r  <= '0;
            attr_r  <= '0;
            pay_r   <= '0;
        end
        else if (rx_byte)
        begin
            if (cnt_r != 4'hF)
                cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h0)
            begin
                cls_r <= link.s2d_data;
                pay_r <= {16'h0000, cmd_r}; // Short writes keep untouched bytes
            end
            else if (cnt_r == 4'h1)
                inst_r <= link.s2d_data;
            else if (cnt_r == 4'h2)
                attr_r <= link.s2d_data;
            else if (pay_idx < 4'(OUT_BYTES))
                pay_r[{pay_idx[1:0], 3'b000} +: 8] <= link.s2d_data;
            if (link.s2d_last)
                state_r <= ST_EVAL;
        end
        else if (state_r == ST_EVAL)
        begin
            cnt_r   <= '0;
            state_r <= good ? ST_TX : ST_RX;
        end
        else if ((state_r == ST_TX) && tx_end)
        begin
            state_r <= ST_RX;
        end
    end

    // Command word and its one-shot effects
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_r  <= CMD_RESET;
            trip_r <= 1'b0;
            rd_r   <= 1'b0;
            bad_r  <= 1'b0;
            snap_r <= '0;
            ip_r   <= DEF_IP;
        end
        else
        begin
            trip_r <= 1'b0;
            rd_r   <= (state_r == ST_EVAL) && is_read;
            bad_r  <= (state_r == ST_EVAL) && !(is_write || is_read);
            if (good)
                snap_r <= snap_nxt;
            // Settings live in flops only, so a power cycle restores the default
            if (cfg_we)
                ip_r <= cfg_ip_in;
            if (reinit)
                cmd_r <= CMD_RESET;
            else if ((state_r == ST_EVAL) && is_write)
            begin
                cmd_r  <= pay_r[15:0];
                trip_r <= pay_r[TRIP_RST_BIT] && !cmd_r[TRIP_RST_BIT];
            end
        end
    end

    // Status reply, registered, one byte per cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_idx_r   <= '0;
            tx_valid_r <= 1'b0;
            tx_data_r  <= '0;
            tx_last_r  <= 1'b0;
        end
        else
        begin
            tx_valid_r <= (state_r == ST_TX);
            tx_last_r  <= (state_r == ST_TX) && tx_end;
            tx_data_r  <= snap_r[{tx_idx_r, 3'b000} +: 8];
            if (state_r == ST_TX)
                tx_idx_r <= tx_end ? 4'h0 : tx_idx_r + 4'h1;
        end
    end

    // Connection watchdog: a good frame proves the link alive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            comm_r <= 1'b0;
            tmo_r  <= 1'b0;
            wd_r   <= '0;
        end
        else if (good)
        begin
            comm_r <= 1'b1;
            tmo_r  <= 1'b0;
            wd_r   <= '0;
        end
        else if (comm_r)
        begin
            if (wd_r >= 32'(TMO_CYC - 1))
            begin
                comm_r <= 1'b0;
                tmo_r  <= 1'b1;
            end
            else
                wd_r <= wd_r + 32'h1;
        end
    end

    fbcd_blink #(
        .HALF_CYC (BLINK_CYC)
    ) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .phase   (blink)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_port
            logic [31:0] hold_r;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    hold_r <= '0;
                else if (s_act[gi])
                    hold_r <= 32'(ACT_CYC);
                else if (hold_r != 32'h0)
                    hold_r <= hold_r - 32'h1;
            end
            // Stretch keeps short bursts lit for ACT_CYC cycles, a fifth of a blink half-period by default
            assign act_hold[gi] = (hold_r != 32'h0);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            led_err_r  <= 1'b0;
            led_stat_r <= 1'b0;
            led_link_r <= '0;
            led_act_r  <= '0;
            sync1_r    <= '0;
            sync2_r    <= '0;
        end
        else
        begin
            led_err_r  <= s_dup || (tmo_r && blink);
            led_stat_r <= comm_r || (s_ip && blink);
            led_link_r <= s_link;
            led_act_r  <= act_hold & {2{blink}};
            sync1_r    <= {port_act, link_up, dup_ip, ip_obtained};
            sync2_r    <= sync1_r;
        end
    end

    assign link.d2s_valid = tx_valid_r;
    assign link.d2s_data  = tx_data_r;
    assign link.d2s_last  = tx_last_r;
    assign start_cmd      = cmd_r[RUN_BIT];
    assign motor_set_sec  = cmd_r[MSET_BIT];
    assign trip_reset     = trip_r;
    assign cmd_word       = cmd_r;
    assign status_read    = rd_r;
    assign bad_frame      = bad_r;
    assign cfg_ip         = ip_r;
    assign led_err        = led_err_r;
    assign led_stat       = led_stat_r;
    assign led_link       = led_link_r;
    assign led_act        = led_act_r;
endmodule

// [core/fbcd_blink.sv]
`timescale 1ns/1ps
module fbcd_blink
    import fbcd_pkg::*;
#(
    parameter int HALF_CYC = BLINK_HALF_CYC
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      phase
);
    logic [31:0] cnt_r;
    logic        phase_r;
    wire         wrap = (cnt_r >= 32'(HALF_CYC - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r   <= '0;
            phase_r <= 1'b0;
        end
        else if (wrap)
        begin
            cnt_r   <= '0;
            phase_r <= ~phase_r;
        end
        else
        begin
            cnt_r <= cnt_r + 32'h1;
        end
    end

    assign phase = phase_r;
endmodule

// [core/fbcd_link_if.sv]
`timescale 1ns/1ps
interface fbcd_link_if;
    logic       s2d_valid;
    logic [7:0] s2d_data;
    logic       s2d_last;
    logic       d2s_valid;
    logic [7:0] d2s_data;
    logic       d2s_last;

    modport adapter
    (
        input  s2d_valid,
        input  s2d_data,
        input  s2d_last,
        output d2s_valid,
        output d2s_data,
        output d2s_last
    );

    modport scanner
    (
        output s2d_valid,
        output s2d_data,
        output s2d_last,
        input  d2s_valid,
        input  d2s_data,
        input  d2s_last
    );
endinterface

// [core/fbcd_pkg.sv]
package fbcd_pkg;

    localparam int          CLK_HZ          = 40_000_000;

    localparam logic [7:0]  ASM_CLASS       = 8'h04;
    localparam logic [7:0]  OUT_INST        = 8'h68;
    localparam logic [7:0]  IN_INST         = 8'h9A;
    localparam logic [7:0]  ASM_ATTR        = 8'h03;
    localparam int          HDR_BYTES       = 3;
    localparam int          OUT_BYTES       = 4;
    localparam int          IN_BYTES        = 12;

    localparam int          RUN_BIT         = 6;
    localparam int          TRIP_RST_BIT    = 7;
    localparam int          MSET_BIT        = 13;
    localparam logic [15:0] CMD_USED_MASK   = 16'h20C0;
    localparam logic [15:0] CMD_RESET       = 16'h0000;
    localparam logic [31:0] DEF_IP          = 32'hC0A80002;

    localparam int          MIN_CYCLE_US    = 1000;
    localparam int          MIN_CYCLE_CYC   = (CLK_HZ / 1_000_000) * MIN_CYCLE_US;
    localparam int          BLINK_HALF_MS   = 250;
    localparam int          BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;
    localparam int          ACT_HOLD_MS     = 50;
    localparam int          ACT_HOLD_CYC    = (CLK_HZ / 1000) * ACT_HOLD_MS;
    localparam int          CONN_TMO_MS     = 100;
    localparam int          CONN_TMO_CYC    = (CLK_HZ / 1000) * CONN_TMO_MS;

    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_CMD         = 8'h04;
    localparam logic [7:0]  REG_STAT        = 8'h08;
    localparam logic [7:0]  REG_RX0         = 8'h0C;
    localparam logic [7:0]  REG_RX1         = 8'h10;
    localparam logic [7:0]  REG_RX2         = 8'h14;
    localparam int          CTRL_EN_BIT     = 0;
    localparam int          CTRL_RD_BIT     = 1;
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          STAT_DONE_BIT   = 1;

endpackage

// [core/fbcd_scanner.sv]
`timescale 1ns/1ps
module fbcd_scanner
    import fbcd_pkg::*;
#(
    parameter int MIN_CYC = MIN_CYCLE_CYC
)
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  psel,
    input  wire logic  penable,
    input  wire logic  pwrite,
    input  wire logic  [7:0] paddr,
    input  wire logic  [31:0] pwdata,
    output logic       [31:0] prdata,
    output logic       pready,
    output logic       pslverr,
    input  wire logic  local_override,
    input  wire logic  reset_input,
    fbcd_link_if.scanner link
);
    typedef enum logic [1:0] {SC_IDLE, SC_SEND, SC_WAIT} fbcd_sc_state_t;

    fbcd_sc_state_t state_r;
    logic [1:0]     sync1_r;
    logic [1:0]     sync2_r;
    logic           en_r;
    logic           rd_req_r;
    logic [15:0]    cmd_r;
    logic           done_r;
    logic [7:0]     rx_r [IN_BYTES];
    logic [3:0]     rx_idx_r;
    logic [31:0]    gap_r;
    logic           expl_r;
    logic [3:0]     idx_r;
    logic           v_r;
    logic [7:0]     d_r;
    logic           l_r;
    logic [31:0]    prdata_r;
    logic [31:0]    rdmux;

    wire        hold_off = sync2_r[0] || sync2_r[1];
    wire [15:0] cmd_tx   = hold_off ? 16'h0000 : (cmd_r & CMD_USED_MASK);
    wire        gap_ok   = (gap_r >= 32'(MIN_CYC));
    wire        go       = (state_r == SC_IDLE) && gap_ok && (rd_req_r || en_r);
    wire        go_expl  = go && rd_req_r;
    wire [3:0]  n_last   = expl_r ? 4'(HDR_BYTES - 1) : 4'(HDR_BYTES + OUT_BYTES - 1);
    wire        snd_end  = (state_r == SC_SEND) && (idx_r == n_last);
    wire        wr       = psel && penable && pwrite;
    wire        setup    = psel && !penable;
    wire        hit      = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_STAT)
                           || (paddr == REG_RX0) || (paddr == REG_RX1) || (paddr == REG_RX2);
    wire        rx_in    = (state_r == SC_WAIT) && link.d2s_valid;
    wire [7:0]  byte_mux = (idx_r == 4'h0) ? ASM_CLASS
                         : (idx_r == 4'h1) ? (expl_r ? IN_INST : OUT_INST)
                         : (idx_r == 4'h2) ? ASM_ATTR
                         : (idx_r == 4'h3) ? cmd_tx[7:0]
                         : (idx_r == 4'h4) ? cmd_tx[15:8]
                         : 8'h00;

    always_comb
    begin
        rdmux = 32'h0;
        if (paddr == REG_CTRL)
            rdmux = {30'h0, rd_req_r, en_r};
        else if (paddr == REG_CMD)
            rdmux = {16'h0, cmd_r};
        else if (paddr == REG_STAT)
            rdmux = {30'h0, done_r, state_r != SC_IDLE};
        else if (paddr == REG_RX0)
            rdmux = {rx_r[3], rx_r[2], rx_r[1], rx_r[0]};
        else if (paddr == REG_RX1)
            rdmux = {rx_r[7], rx_r[6], rx_r[5], rx_r[4]};
        else if (paddr == REG_RX2)
            rdmux = {rx_r[11], rx_r[10], rx_r[9], rx_r[8]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r  <= '0;
            sync2_r  <= '0;
            prdata_r <= '0;
            en_r     <= 1'b0;
            cmd_r    <= CMD_RESET;
        end
        else
        begin
            sync1_r <= {reset_input, local_override};
            sync2_r <= sync1_r;
            if (setup)
                prdata_r <= rdmux;
            if (wr && (paddr == REG_CTRL))
                en_r <= pwdata[CTRL_EN_BIT];
            if (wr && (paddr == REG_CMD))
                cmd_r <= pwdata[15:0];
        end
    end

    // Request and done flags: hardware action wins over software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_req_r <= 1'b0;
            done_r   <= 1'b0;
        end
        else
        begin
            if (go_expl)
                rd_req_r <= 1'b0;
            else if (wr && (paddr == REG_CTRL) && pwdata[CTRL_RD_BIT])
                rd_req_r <= 1'b1;
            if (rx_in && link.d2s_last)
                done_r <= 1'b1;
            else if (wr && (paddr == REG_STAT) && pwdata[STAT_DONE_BIT])
                done_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r  <= SC_IDLE;
            gap_r    <= 32'(MIN_CYC);
            expl_r   <= 1'b0;
            idx_r    <= '0;
            rx_idx_r <= '0;
            v_r      <= 1'b0;
            d_r      <= '0;
            l_r      <= 1'b0;
        end
        else
        begin
            v_r <= (state_r == SC_SEND);
            d_r <= byte_mux;
            l_r <= snd_end;
            if (go)
                gap_r <= '0;
            else if (!gap_ok)
                gap_r <= gap_r + 32'h1;
            unique case (state_r)
                SC_IDLE:
                begin
                    idx_r    <= '0;
                    rx_idx_r <= '0;
                    if (go)
                    begin
                        expl_r  <= go_expl;
                        state_r <= SC_SEND;
                    end
                end
                SC_SEND:
                begin
                    idx_r <= idx_r + 4'h1;
                    if (snd_end)
                        state_r <= SC_WAIT;
                end
                SC_WAIT:
                begin
                    if (rx_in && link.d2s_last)
                        state_r <= SC_IDLE;
                    if (rx_in && (rx_idx_r != 4'hF))
                        rx_idx_r <= rx_idx_r + 4'h1;
                end
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < IN_BYTES; gi++)
        begin : g_rx
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    rx_r[gi] <= '0;
                else if (rx_in && (rx_idx_r == 4'(gi)))
                    rx_r[gi] <= link.d2s_data;
            end
        end
    endgenerate

    assign link.s2d_valid = v_r;
    assign link.s2d_data  = d_r;
    assign link.s2d_last  = l_r;
    assign prdata         = prdata_r;
    assign pready         = 1'b1;
    assign pslverr        = psel && penable && !hit;
endmodule

// [tb/fbcd_props.sv]
`timescale 1ns/1ps
module fbcd_props
    import fbcd_pkg::*;
#(
    parameter int MIN_CYC = 30
)
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       s2d_valid,
    input wire logic [7:0] s2d_data,
    input wire logic       s2d_last,
    input wire logic       d2s_valid,
    input wire logic [7:0] d2s_data,
    input wire logic       d2s_last
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic        prev_r;
    logic [15:0] gap_r;
    wire         start = s2d_valid && !prev_r;

    // Cycles since the last frame start, saturating so idle time never wraps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_r <= 1'b0;
            gap_r  <= 16'hFFFF;
        end
        else
        begin
            prev_r <= s2d_valid;
            gap_r  <= start ? 16'h0001 : gap_r + {15'h0000, gap_r != 16'hFFFF};
        end
    end

    AST_PATH: assert property (start |-> s2d_data == ASM_CLASS ##1
        (s2d_data == OUT_INST || s2d_data == IN_INST) ##1 s2d_data == ASM_ATTR)
        else $error("bad frame path");
    AST_WR_LEN: assert property (start ##1 s2d_data == OUT_INST |->
        ##1 (s2d_valid && !s2d_last) [*4] ##1 (s2d_valid && s2d_last))
        else $error("bad write length");
    AST_RSVD: assert property (start ##1 s2d_data == OUT_INST |-> ##2
        (s2d_data & 8'h3F) == 8'h00 ##1 (s2d_data & 8'hDF) == 8'h00
        ##1 s2d_data == 8'h00 ##1 s2d_data == 8'h00)
        else $error("reserved bit set");
    AST_RD_LEN: assert property (start ##1 s2d_data == IN_INST |->
        ##1 (s2d_valid && s2d_last))
        else $error("bad read length");
    AST_SPACING: assert property (start |-> gap_r >= 16'(MIN_CYC))
        else $error("frames too close");
    AST_REPLY_TIME: assert property (s2d_last |-> ##1 !d2s_valid ##[1:2] d2s_valid)
        else $error("no reply");
    AST_REPLY_LEN: assert property ($rose(d2s_valid) |->
        (d2s_valid && !d2s_last) [*8] ##1 (d2s_valid && !d2s_last) [*3] ##1 d2s_last)
        else $error("bad reply length");
    AST_DUPLEX: assert property (d2s_valid |-> !s2d_valid)
        else $error("send during reply");
endmodule

// [tb/fieldbus_command_decoder_tb.sv]
`timescale 1ns/1ps
module fieldbus_command_decoder_tb
    import fbcd_pkg::*;
;
    localparam logic [15:0] TC [5] = '{16'hFFFF, 16'h0040, 16'h0080, 16'h0000, 16'h00C0};
    localparam logic [15:0] TW [5] = '{16'h20C0, 16'h0040, 16'h0080, 16'h0000, 16'h00C0};
    localparam int          TT [5] = '{1, 0, 1, 0, 1};

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, bad_frame;
    logic        local_override, reset_input, reinit, ip_obtained, dup_ip, cfg_we;
    logic        start_cmd, trip_reset, motor_set_sec, status_read, led_err, led_stat;
    logic [1:0]  link_up, port_act, led_link, led_act;
    logic [2:0]  led_q;
    logic [7:0]  paddr;
    logic [15:0] starter_state, trip_code, cmd_word;
    logic [31:0] pwdata, prdata, motor_current, cfg_ip_in, cfg_ip, rd_q;
    int          err_count, total_checks, cyc, trips, reads, bads, n;
    int          tg [3];
    wire  [2:0]  leds = {led_act[0], led_stat, led_err};

    fbcd_link_if lk ();
    fbcd_scanner #(.MIN_CYC(30)) i_fbcd_scanner
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .local_override, .reset_input, .link(lk)
    );
    // Short blink and timeout counts keep the run brief
    fbcd_adapter #(.BLINK_CYC(4), .ACT_CYC(8), .TMO_CYC(200)) i_fbcd_adapter
    (
        .pclk, .presetn, .link(lk), .reinit, .ip_obtained, .dup_ip, .link_up, .port_act,
        .starter_state, .motor_current, .trip_code, .cfg_we, .cfg_ip_in, .start_cmd,
        .trip_reset, .motor_set_sec, .cmd_word, .status_read, .bad_frame, .cfg_ip,
        .led_err, .led_stat, .led_link, .led_act
    );
    fbcd_props #(.MIN_CYC(30)) i_fbcd_props
    (
        .pclk, .presetn, .s2d_valid(lk.s2d_valid), .s2d_data(lk.s2d_data),
        .s2d_last(lk.s2d_last), .d2s_valid(lk.d2s_valid), .d2s_data(lk.d2s_data),
        .d2s_last(lk.d2s_last)
    );

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        led_q <= leds;
        for (int i = 0; i < 3; i++)
            if (leds[i] !== led_q[i]) tg[i]++;
        if (trip_reset === 1'b1) trips++;
        if (status_read === 1'b1) reads++;
        if (bad_frame === 1'b1) bads++;
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            complete_run;
        end
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task frames(input int k);
        repeat (k)
        begin
            @(posedge pclk);
            while (lk.d2s_last !== 1'b1) @(posedge pclk);
        end
    endtask

    task complete_run;
        $display("Checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task t_leds;
        chk("cfg_ip", cfg_ip, DEF_IP);
        cfg_ip_in <= 32'h0A000001;
        cfg_we <= 1'b1;
        @(posedge pclk);
        cfg_we <= 1'b0;
        @(posedge pclk);
        chk("cfg_set", cfg_ip, 32'h0A000001);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("cfg_lost", cfg_ip, DEF_IP);
        ip_obtained <= 1'b1;
        link_up <= 2'b10;
        dup_ip <= 1'b1;
        port_act <= 2'b01;
        repeat (6) @(posedge pclk);
        tg = '{0, 0, 0};
        repeat (20) @(posedge pclk);
        chk("led_err", led_err, 1'b1);
        chk("led_link", led_link, 2'b10);
        chk("act1_off", led_act[1], 1'b0);
        chk("stat_flash", tg[1] > 0, 1'b1);
        chk("act_flash", tg[2] > 0, 1'b1);
        dup_ip <= 1'b0;
        port_act <= 2'b00;
    endtask

    task t_cmds;
        apb(1'b1, REG_CTRL, 32'h1);
        for (int i = 0; i < 5; i++)
        begin
            n = trips;
            apb(1'b1, REG_CMD, {16'h0000, TC[i]});
            frames(2);
            chk("cmd_word", cmd_word, TW[i]);
            chk("start", start_cmd, TW[i][RUN_BIT]);
            chk("mset", motor_set_sec, TW[i][MSET_BIT]);
            chk("trips", trips - n, TT[i]);
        end
        chk("stat_on", led_stat, 1'b1);
        chk("err_off", led_err, 1'b0);
    endtask

    task t_hold;
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (60) @(posedge pclk);
        chk("held", cmd_word, 16'h00C0);
        apb(1'b1, REG_STAT, 32'h2);
        n = reads;
        apb(1'b1, REG_CTRL, 32'h2);
        rd_q = '0;
        while (rd_q[STAT_DONE_BIT] !== 1'b1) apb(1'b0, REG_STAT, 32'h0);
        chk("status_read", reads - n, 1);
        apb(1'b0, REG_RX0, 32'h0);
        chk("rx0", rd_q, {16'h0000, starter_state});
        apb(1'b0, REG_RX1, 32'h0);
        chk("rx1", rd_q, motor_current);
        apb(1'b0, REG_RX2, 32'h0);
        chk("rx2", rd_q, {16'h0000, trip_code});
        reinit <= 1'b1;
        @(posedge pclk);
        reinit <= 1'b0;
        @(posedge pclk);
        chk("reinit", {start_cmd, cmd_word}, 32'h0);
        n = trips;
        apb(1'b1, REG_CTRL, 32'h1);
        frames(2);
        chk("trip_again", trips - n, 1);
    endtask

    task t_override;
        for (int k = 0; k < 2; k++)
        begin
            local_override <= (k == 0);
            reset_input <= (k == 1);
            frames(3);
            chk("cleared", cmd_word, 16'h0000);
        end
        reset_input <= 1'b0;
        frames(3);
        chk("resent", cmd_word, 16'h00C0);
    endtask

    task t_tmo;
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (230) @(posedge pclk);
        tg[0] = 0;
        repeat (20) @(posedge pclk);
        chk("err_flash", tg[0] > 0, 1'b1);
        apb(1'b0, 8'hFC, 32'h0);
        chk("slverr", err_q, 1'b1);
        chk("unmapped", rd_q, 32'h0);
        chk("bad_frame", bads, 0);
    endtask

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {local_override, reset_input, reinit, ip_obtained, dup_ip, cfg_we} = '0;
        {link_up, port_act, cfg_ip_in} = '0;
        starter_state = 16'hA5C3;
        motor_current = 32'h00010D42;
        trip_code = 16'h1234;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_leds;
        t_cmds;
        t_hold;
        t_override;
        t_tmo;
        complete_run;
    end
endmodule
